/* File: hw/gcca_global_config.sv */
// global configuration register with line clock activity and aux bus controls
`timescale 1ns/100ps
module gcca_global_config
    import gcca_pkg::*;
#(
    parameter int GROUPS = gcca_pkg::GCCA_GROUPS,
    parameter int ABSENT_CYCLES = gcca_pkg::GCCA_ABSENT_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // soft resets, one-cycle pulses
    input wire logic [GROUPS-1:0] soft_group_rst,
    input wire logic soft_chip_rst,
    // serial port line clocks
    input wire logic [GROUPS-1:0] tx_line_clock,
    input wire logic [GROUPS-1:0] rx_line_clock,
    // descriptor load from shared memory
    input wire gcca_pkg::gcca_load_t desc_load,
    // register read port
    input wire logic reg_rd,
    output logic reg_rd_valid_q,
    output logic [31:0] reg_rd_data_q,
    // group ram gate
    input wire gcca_pkg::gcca_ram_req_t ram_req,
    input wire logic [31:0] ram_rdata,
    output logic ram_wr_allow,
    output logic ram_rd_valid_q,
    output logic [31:0] ram_rd_data_q,
    // expansion bus release pacing
    input wire logic bus_released,
    output logic bus_request_ok,
    // aux bus clock pin
    output logic aux_bus_clock_o,
    output logic aux_bus_clock_oe
);
    import gcca_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    initial begin
        if (GROUPS != 8) $error("gcca_global_config: register layout serves exactly 8 groups");
        if (ABSENT_CYCLES < 2) $error("gcca_global_config: ABSENT_CYCLES too small");
    end

    gcca_cfg_t cfg_q;
    logic [GROUPS-1:0] tx_seen;
    logic [GROUPS-1:0] rx_seen;
    logic [GROUPS-1:0] tx_present;
    logic [GROUPS-1:0] rx_present;
    logic [GROUPS-1:0] tx_sel_clk;
    logic [GROUPS-1:0] rx_sel_clk;
    logic [GROUPS-1:0] grp_clear;
    logic [3:0] gap_cnt_q;
    logic [31:0] word;
    logic grp_alive;

    // ------------------------------------------------------------
    // configuration load, group 0 copy only
    // ------------------------------------------------------------
    // other groups' copies are ignored so a stale copy can never win
    // descriptor words are only read here, nothing goes back to memory
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q.bus_release_gap <= GCCA_GAP_RESET;
            cfg_q.aux_clock_output_on <= GCCA_AUXCLK_RESET;
            cfg_q.portmap <= GCCA_PORTMAP_RESET;
        end else if (desc_load.valid && desc_load.group == GCCA_CONFIG_GROUP) begin
            cfg_q.bus_release_gap <= desc_load.data[GCCA_GAP_LSB +: 3];
            cfg_q.aux_clock_output_on <= desc_load.data[GCCA_AUXCLK_BIT];
            cfg_q.portmap <= desc_load.data[GCCA_PORTMAP_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // port to group clock routing
    // ------------------------------------------------------------
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            case (gcca_portmap_t'(cfg_q.portmap))
                GCCA_MAP_PAIRS: begin
                    tx_sel_clk[g] = tx_line_clock[g / 2];
                    rx_sel_clk[g] = rx_line_clock[g / 2];
                end
                GCCA_MAP_QUADS: begin
                    tx_sel_clk[g] = tx_line_clock[g / 4];
                    rx_sel_clk[g] = rx_line_clock[g / 4];
                end
                // reserved code falls back to one port per group
                default: begin
                    tx_sel_clk[g] = tx_line_clock[g];
                    rx_sel_clk[g] = rx_line_clock[g];
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // group clears
    // ------------------------------------------------------------
    assign grp_clear = soft_group_rst | {GROUPS{soft_chip_rst}};

    // ------------------------------------------------------------
    // activity detectors
    // ------------------------------------------------------------
    // each: two-flop sync, set on second edge, held until a read or a group clear clears it
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        gcca_clk_seen #(.ABSENT_CYCLES(ABSENT_CYCLES)) u_tx (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .line_clock(tx_sel_clk[g]),
            .grp_clear(grp_clear[g]),
            .read_clear(reg_rd),
            .seen_q(tx_seen[g]),
            .present(tx_present[g])
        );
        gcca_clk_seen #(.ABSENT_CYCLES(ABSENT_CYCLES)) u_rx (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .line_clock(rx_sel_clk[g]),
            .grp_clear(grp_clear[g]),
            .read_clear(reg_rd),
            .seen_q(rx_seen[g]),
            .present(rx_present[g])
        );
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_comb begin
        word = '0; // reserved and omitted fields read zero
        word[GCCA_TX_HI_LSB +: 4] = tx_seen[7:4];
        word[GCCA_RX_HI_LSB +: 4] = rx_seen[7:4];
        word[GCCA_TX_LO_LSB +: 4] = tx_seen[3:0];
        word[GCCA_RX_LO_LSB +: 4] = rx_seen[3:0];
        word[GCCA_GAP_LSB +: 3] = cfg_q.bus_release_gap;
        word[GCCA_AUXCLK_BIT] = cfg_q.aux_clock_output_on;
        word[GCCA_PORTMAP_LSB +: 2] = cfg_q.portmap;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rd_valid_q <= 1'b0;
        end else begin
            reg_rd_valid_q <= reg_rd;
        end
    end

    // word holds until the next read, so a slow host still sees it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rd_data_q <= '0;
        end else if (reg_rd) begin
            reg_rd_data_q <= word;
        end
    end

    // ------------------------------------------------------------
    // group ram gate
    // ------------------------------------------------------------
    // both directions must run: the group logic needs its own clocks
    assign grp_alive = tx_present[ram_req.group] && rx_present[ram_req.group];
    assign ram_wr_allow = ram_req.wr && grp_alive;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ram_rd_valid_q <= 1'b0;
        end else begin
            ram_rd_valid_q <= ram_req.rd;
        end
    end

    // an absent group never leaks stale ram contents
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ram_rd_data_q <= '0;
        end else if (ram_req.rd) begin
            ram_rd_data_q <= grp_alive ? ram_rdata : GCCA_DEAD_ACCESS;
        end
    end

    // ------------------------------------------------------------
    // expansion bus release gap
    // ------------------------------------------------------------
    // aux clock is core clock inverted, so one aux period is one cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt_q <= '0;
        end else if (bus_released) begin
            gap_cnt_q <= {1'b0, cfg_q.bus_release_gap} + GCCA_GAP_BASE;
        end else if (gap_cnt_q != 4'h0) begin
            gap_cnt_q <= gap_cnt_q - 4'h1;
        end
    end

    assign bus_request_ok = (gap_cnt_q == 4'h0) && !bus_released;

    // ------------------------------------------------------------
    // aux bus clock pin
    // ------------------------------------------------------------
    assign aux_bus_clock_o = ~core_clk;
    // oe low leaves the pad undriven; the pad cell does the tristate
    assign aux_bus_clock_oe = cfg_q.aux_clock_output_on;
endmodule : gcca_global_config

/* File: hw/gcca_pkg.sv */
// shared constants and types for the global configuration / clock activity block
package gcca_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int GCCA_GROUPS = 8;
    localparam int GCCA_PORTS = 8;
    localparam logic [2:0] GCCA_CONFIG_GROUP = 3'h0;
    // ------------------------------------------------------------
    // field positions of the global configuration word
    // ------------------------------------------------------------
    localparam int GCCA_TX_HI_LSB = 28;
    localparam int GCCA_RX_HI_LSB = 24;
    localparam int GCCA_TX_LO_LSB = 20;
    localparam int GCCA_RX_LO_LSB = 16;
    localparam int GCCA_RSVD_BIT = 15;
    localparam int GCCA_GAP_LSB = 12;
    localparam int GCCA_AUXCLK_BIT = 11;
    localparam int GCCA_PORTMAP_LSB = 0;
    // ------------------------------------------------------------
    // reset values and fixed words
    // ------------------------------------------------------------
    localparam logic [2:0] GCCA_GAP_RESET = 3'h0;
    localparam logic GCCA_AUXCLK_RESET = 1'b0;
    localparam logic [1:0] GCCA_PORTMAP_RESET = 2'h0;
    localparam logic [31:0] GCCA_DEAD_ACCESS = 32'hdeadacce;
    localparam logic [3:0] GCCA_GAP_BASE = 4'h4;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int GCCA_CLK_PERIOD_NS = 25;
    localparam int GCCA_ABSENT_NS = 25600;
    localparam int GCCA_ABSENT_CYCLES = GCCA_ABSENT_NS / GCCA_CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GCCA_MAP_ONE_TO_ONE,
        GCCA_MAP_PAIRS,
        GCCA_MAP_QUADS,
        GCCA_MAP_RESERVED
    } gcca_portmap_t;

    typedef struct packed {
        logic [2:0] bus_release_gap;
        logic aux_clock_output_on;
        logic [1:0] portmap;
    } gcca_cfg_t;

    typedef struct packed {
        logic valid;
        logic [2:0] group;
        logic [31:0] data;
    } gcca_load_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] group;
    } gcca_ram_req_t;
endpackage : gcca_pkg

/* File: hw/gcca_clk_seen.sv */
// per-group line clock activity detector
`timescale 1ns/100ps
module gcca_clk_seen #(
    parameter int ABSENT_CYCLES = 1024
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // line clock and controls
    input wire logic line_clock,
    input wire logic grp_clear,
    input wire logic read_clear,
    // status
    output logic seen_q,
    output logic present
);
    localparam int CW = $clog2(ABSENT_CYCLES + 1);
    localparam logic [CW-1:0] TO_MAX = CW'(ABSENT_CYCLES);

    initial begin
        if (ABSENT_CYCLES < 2) $error("gcca_clk_seen: ABSENT_CYCLES too small");
    end

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic first_q;
    logic [CW-1:0] idle_q;
    logic rise;

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= line_clock;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise = sync2_q && !prev_q;

    // ------------------------------------------------------------
    // activity bit: second edge while clear; set beats read clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_q <= 1'b0;
            first_q <= 1'b0;
        end else if (grp_clear) begin
            seen_q <= 1'b0;
            first_q <= 1'b0;
        end else if (rise && !seen_q && first_q) begin
            seen_q <= 1'b1;
            first_q <= 1'b0;
        end else if (rise && !seen_q) begin
            first_q <= !read_clear;
        end else if (read_clear) begin
            seen_q <= 1'b0;
            first_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // absence: no edge for a whole timeout window
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_q <= TO_MAX;
        end else if (rise) begin
            idle_q <= '0;
        end else if (idle_q != TO_MAX) begin
            idle_q <= idle_q + CW'(1);
        end
    end

    assign present = (idle_q != TO_MAX);
endmodule : gcca_clk_seen

/* File: testbench/gcca_global_config_props.sv */
// port assertions for the global configuration block
`timescale 1ns/100ps
module gcca_global_config_props
    import gcca_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // inputs
    input wire logic soft_chip_rst,
    input wire gcca_pkg::gcca_load_t desc_load,
    input wire logic reg_rd,
    input wire gcca_pkg::gcca_ram_req_t ram_req,
    input wire logic [31:0] ram_rdata,
    input wire logic bus_released,
    // outputs
    input wire logic reg_rd_valid_q,
    input wire logic [31:0] reg_rd_data_q,
    input wire logic ram_wr_allow,
    input wire logic ram_rd_valid_q,
    input wire logic [31:0] ram_rd_data_q,
    input wire logic bus_request_ok,
    input wire logic aux_bus_clock_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----
    // shadow of gap field and release wait
    // ----
    logic [2:0] gap_q;
    logic [3:0] wait_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) gap_q <= 3'h0;
        else if (desc_load.valid && desc_load.group == GCCA_CONFIG_GROUP) gap_q <= desc_load.data[14:12];
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) wait_q <= 4'h0;
        else if (bus_released) wait_q <= GCCA_GAP_BASE + {1'b0, gap_q};
        else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    end
    rd_valid_a: assert property (reg_rd |=> reg_rd_valid_q) else $error("read valid missing");
    rd_valid_one_a: assert property (!reg_rd |=> !reg_rd_valid_q) else $error("stray read valid");
    rsvd_zero_a: assert property (reg_rd_valid_q |-> reg_rd_data_q[15] == 1'b0 && reg_rd_data_q[10:2] == 9'h0)
        else $error("unused bits not zero");
    cfg_echo_a: assert property (reg_rd_valid_q && !$past(desc_load.valid)
        |-> reg_rd_data_q[14:11] == {gap_q, aux_bus_clock_oe}) else $error("config echo wrong");
    oe_load_a: assert property (desc_load.valid && desc_load.group == GCCA_CONFIG_GROUP
        |=> aux_bus_clock_oe == $past(desc_load.data[11])) else $error("enable not loaded");
    oe_ignore_a: assert property (desc_load.valid && desc_load.group != GCCA_CONFIG_GROUP
        |=> $stable(aux_bus_clock_oe)) else $error("other group loaded");
    gap_low_a: assert property (wait_q != 4'h0 || bus_released |-> !bus_request_ok)
        else $error("request allowed early");
    gap_end_a: assert property (wait_q == 4'h0 && !bus_released |-> bus_request_ok)
        else $error("request held too long");
    wr_gate_a: assert property (ram_wr_allow |-> ram_req.wr) else $error("write allowed unasked");
    ram_rd_a: assert property (ram_req.rd |=> ram_rd_valid_q && (ram_rd_data_q == $past(ram_rdata)
        || ram_rd_data_q == GCCA_DEAD_ACCESS)) else $error("ram read wrong");
    chip_clr_a: assert property (soft_chip_rst ##1 reg_rd |=> reg_rd_data_q[31:16] == 16'h0)
        else $error("chip reset left activity");
endmodule : gcca_global_config_props
bind gcca_global_config gcca_global_config_props u_props (
    .core_clk(core_clk), .rst_b(rst_b), .soft_chip_rst(soft_chip_rst), .desc_load(desc_load),
    .reg_rd(reg_rd), .ram_req(ram_req), .ram_rdata(ram_rdata), .bus_released(bus_released),
    .reg_rd_valid_q(reg_rd_valid_q), .reg_rd_data_q(reg_rd_data_q), .ram_wr_allow(ram_wr_allow),
    .ram_rd_valid_q(ram_rd_valid_q), .ram_rd_data_q(ram_rd_data_q), .bus_request_ok(bus_request_ok),
    .aux_bus_clock_oe(aux_bus_clock_oe)
);

/* File: testbench/gcca_host_model.sv */
// host model handing descriptor words to the block
`timescale 1ns/100ps
module gcca_host_model
    import gcca_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bench request
    input wire logic load_go,
    input wire logic [2:0] load_group,
    input wire logic [31:0] load_word,
    // descriptor word
    output gcca_pkg::gcca_load_t desc_load
);
    // idle word inverts each cycle so a stale value is never mistaken for data
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            desc_load <= '0;
        end else begin
            desc_load.valid <= load_go; // one word per request
            desc_load.group <= load_go ? load_group : ~desc_load.group;
            desc_load.data <= load_go ? {17'h0, load_word[14:0]} : ~desc_load.data;
        end
    end
endmodule : gcca_host_model

/* File: testbench/tb_top.sv */
// self-checking bench for the global configuration block
`timescale 1ns/100ps
module tb_top;
    import gcca_pkg::*;
    localparam int ABS = 8;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] soft_group_rst = 8'h0;
    logic soft_chip_rst = 1'b0;
    logic [7:0] tx_en = 8'h0;
    logic [7:0] rx_en = 8'h0;
    logic lclk = 1'b0;
    logic reg_rd = 1'b0;
    gcca_ram_req_t ram_req = '0;
    logic [31:0] ram_rdata = 32'h5a3c9617;
    logic bus_released = 1'b0;
    logic load_go = 1'b0;
    logic [2:0] load_group = 3'h0;
    logic [31:0] load_word = 32'h0;
    gcca_load_t desc_load;
    logic rd_v, wr_ok, ram_v, req_ok, aux_o, aux_oe;
    logic [31:0] rd_d, ram_d;
    logic [2:0] gap = 3'h0;
    logic en = 1'b0;
    logic [1:0] pm = 2'h0;
    int errors = 0;
    int cmp_count = 0;
    // ----
    // clocks, partner and design
    // ----
    initial forever #12.5 core_clk = ~core_clk;
    // line clock 3 cycles high, 3 low; held low while a port is off
    always begin
        repeat (3) @(posedge core_clk);
        lclk <= ~lclk;
    end
    gcca_host_model u_host (.core_clk(core_clk), .rst_b(rst_b), .load_go(load_go), .load_group(load_group),
        .load_word(load_word), .desc_load(desc_load));
    gcca_global_config #(.ABSENT_CYCLES(ABS)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .soft_group_rst(soft_group_rst), .soft_chip_rst(soft_chip_rst), .tx_line_clock(tx_en & {8{lclk}}),
        .rx_line_clock(rx_en & {8{lclk}}), .desc_load(desc_load), .reg_rd(reg_rd), .reg_rd_valid_q(rd_v),
        .reg_rd_data_q(rd_d), .ram_req(ram_req), .ram_rdata(ram_rdata), .ram_wr_allow(wr_ok),
        .ram_rd_valid_q(ram_v), .ram_rd_data_q(ram_d), .bus_released(bus_released), .bus_request_ok(req_ok),
        .aux_bus_clock_o(aux_o), .aux_bus_clock_oe(aux_oe));
    // ----
    // shared tasks
    // ----
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] route(input logic [7:0] p);
        for (int g = 0; g < 8; g++) route[g] = p[pm == 2'h1 ? g / 2 : pm == 2'h2 ? g / 4 : g];
    endfunction : route
    function automatic logic [31:0] word(input logic [7:0] t, input logic [7:0] r);
        return {t[7:4], r[7:4], t[3:0], r[3:0], 1'b0, gap, en, 9'h0, pm};
    endfunction : word
    task automatic rd(input logic [31:0] exp);
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        chk({31'h0, rd_v}, 32'h1);
        chk(rd_d, exp);
    endtask : rd
    task automatic load(input logic [2:0] g, input logic [31:0] w);
        load_go = 1'b1;
        load_group = g;
        load_word = w;
        step(1);
        load_go = 1'b0;
        step(1);
        if (g == 3'h0) {gap, en, pm} = {w[14:11], w[1:0]};
    endtask : load
    task automatic ram(input logic [2:0] g, input logic [31:0] exp, input logic ok);
        ram_req = {1'b0, 1'b1, g};
        #1 chk({31'h0, wr_ok}, {31'h0, ok});
        step(1);
        ram_req = {1'b1, 1'b0, g};
        step(1);
        ram_req = '0;
        chk({31'h0, ram_v}, 32'h1);
        chk(ram_d, exp);
    endtask : ram
    task automatic wait_lclk(input logic lvl);
        int n;
        n = 0;
        while (lclk !== lvl && n < 8) begin
            step(1);
            n++;
        end
        if (n == 8) begin
            errors++;
            end_sim();
        end
    endtask : wait_lclk
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // ----
    // scenarios
    // ----
    task automatic t_idle;
        rd(word(8'h0, 8'h0));
        ram(3'h3, GCCA_DEAD_ACCESS, 1'b0);
    endtask : t_idle
    task automatic t_act;
        for (int m = 0; m < 3; m++) begin
            load(3'h0, m);
            wait_lclk(1'b0);
            tx_en = 8'h10;
            rx_en = 8'h02;
            wait_lclk(1'b1);
            step(3);
            rd(word(8'h0, 8'h0)); // one edge is not enough
            step(40);
            rd(word(route(tx_en), route(rx_en)));
            step(1);
            rd(word(8'h0, 8'h0));
            step(40);
            soft_chip_rst = 1'b1;
            step(1);
            soft_chip_rst = 1'b0;
            rd(word(8'h0, 8'h0));
            tx_en = 8'h0;
            rx_en = 8'h0;
            step(4);
            rd(word(8'h0, 8'h0));
        end
    endtask : t_act
    task automatic t_group;
        load(3'h0, 32'h0);
        tx_en = 8'h28;
        rx_en = 8'h28;
        step(40);
        ram(3'h3, ram_rdata, 1'b1);
        soft_group_rst = 8'h20;
        step(1);
        soft_group_rst = 8'h0;
        rd(word(8'h08, 8'h08));
        tx_en = 8'h0;
        rx_en = 8'h0;
        step(ABS + 8);
        ram(3'h3, GCCA_DEAD_ACCESS, 1'b0);
    endtask : t_group
    task automatic t_bus;
        int n;
        for (int k = 0; k < 8; k += 7) begin
            load(3'h0, k << 12);
            rd(word(8'h0, 8'h0));
            bus_released = 1'b1;
            #1 chk({31'h0, req_ok}, 32'h0);
            step(1);
            bus_released = 1'b0;
            n = 0;
            while (!req_ok && n < 20) begin
                step(1);
                n++;
            end
            chk(n, k + 4);
            if (n == 20) end_sim();
        end
    endtask : t_bus
    task automatic t_aux;
        load(3'h3, 32'h800);
        chk({31'h0, aux_oe}, 32'h0);
        load(3'h0, 32'h800);
        chk({aux_oe, aux_o}, 32'h2);
        #13 chk({aux_oe, aux_o}, 32'h3);
        step(1);
        rd(word(8'h0, 8'h0));
        load(3'h0, 32'h0);
        chk({31'h0, aux_oe}, 32'h0);
    endtask : t_aux
    initial begin
        repeat (16) @(posedge core_clk);
        #1 rst_b = 1'b1;
        t_idle();
        t_act();
        t_group();
        t_bus();
        t_aux();
        end_sim();
    end
endmodule : tb_top
